// ==== src/csd_defines.svh ====
// Offsets, field positions, reset values and commands of the chip-select decoder
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH
// ****************************************
// Register indices and address width
// ****************************************
`define CSD_IDX_CONTROL      8'h44
`define CSD_IDX_HOLE_BOTTOM  8'h45
`define CSD_IDX_HOLE_TOP     8'h46
`define CSD_IDX_TOP_OF_MEM   8'h47
`define CSD_ADDR_WIDTH       12
// ****************************************
// Control fields
// ****************************************
`define CSD_BIT_MID_RD       0
`define CSD_BIT_MID_WR       1
`define CSD_BIT_BIOS_RD      2
`define CSD_BIT_BIOS_WR      3
`define CSD_BIT_MASTER_EN    4
`define CSD_CONTROL_MASK     8'h1f
// ****************************************
// Reset values
// ****************************************
`define CSD_RST_CONTROL      8'h00
`define CSD_RST_HOLE_BOTTOM  8'h10
`define CSD_RST_HOLE_TOP     8'h0f
`define CSD_RST_TOP_OF_MEM   8'h00
// ****************************************
// PCI memory commands
// ****************************************
`define CSD_CMD_MEM_RD       4'h6
`define CSD_CMD_MEM_WR       4'h7
`define CSD_CMD_MEM_RD_MULT  4'hc
`define CSD_CMD_MEM_RD_LINE  4'he
`define CSD_CMD_MEM_WR_INV   4'hf
`endif

// ==== src/csd_pkg.sv ====
// Types shared by the chip-select decoder
package csd_pkg;
  typedef logic [7:0] csd_reg_type;
  typedef enum logic [1:0] {
    csd_none,
    csd_read,
    csd_write
  } csd_dir_type;
endpackage

// ==== src/csd_decoder.sv ====
// Main memory chip-select decoder with AHB-Lite register slave
`timescale 1ns/1ns
`include "csd_defines.svh"

module csd_decoder
  import csd_pkg::*;
(
  input  wire logic                clk,                       // 50 MHz clock
  input  wire logic                reset_n,                   // Sync reset
  input  wire logic                hsel,                      // AHB select
  input  wire logic [31:0]         haddr,                     // AHB address
  input  wire logic [1:0]          htrans,                    // AHB transfer type
  input  wire logic                hwrite,                    // AHB write
  input  wire logic [2:0]          hsize,                     // AHB size
  input  wire logic [31:0]         hwdata,                    // AHB write data
  input  wire logic                hready,                    // AHB bus ready
  output logic      [31:0]         hrdata,                    // AHB read data
  output logic                     hreadyout,                 // AHB slave ready
  output logic                     hresp,                     // AHB response
  input  wire logic                pci_addr_phase,            // Address phase strobe
  input  wire logic [31:0]         pci_ad,                    // Address lines
  input  wire logic [3:0]          pci_cmd,                   // Bus command
  output logic                     main_memory_chip_select_n, // Chip-select, low
  output logic                     positive_decode_disable    // Subtractive claim
);
  import csd_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  csd_reg_type control;
  csd_reg_type hole_bottom_value;
  csd_reg_type hole_top_value;
  csd_reg_type top_of_memory;
  logic        master_en;

  assign master_en = control[`CSD_BIT_MASTER_EN];

  // ****************************************
  // Bus slave
  // ****************************************
  logic                         wr_pending;
  logic [`CSD_ADDR_WIDTH-1:0]   wr_addr;
  logic                         access;
  logic [`CSD_ADDR_WIDTH-1:0]   rd_addr;
  logic [31:0]                  wr_word;
  logic [31:0]                  next_rdata;

  assign access  = hsel && hready && htrans[1];
  assign rd_addr = haddr[`CSD_ADDR_WIDTH-1:0];

  // Write data arrives a cycle after its address
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_pending <= 1'b0;
      wr_addr    <= '0;
    end else if (hready) begin
      wr_pending <= access && hwrite;
      wr_addr    <= rd_addr;
    end
  end

  function automatic logic [`CSD_ADDR_WIDTH-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'h0, idx, 2'h0};
  endfunction

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      control           <= `CSD_RST_CONTROL;
      hole_bottom_value <= `CSD_RST_HOLE_BOTTOM;
      hole_top_value    <= `CSD_RST_HOLE_TOP;
      top_of_memory     <= `CSD_RST_TOP_OF_MEM;
    end else if (wr_pending) begin
      if (wr_addr == byte_addr(`CSD_IDX_CONTROL)) begin
        control <= hwdata[7:0] & `CSD_CONTROL_MASK;
      end
      if (wr_addr == byte_addr(`CSD_IDX_HOLE_BOTTOM)) begin
        hole_bottom_value <= hwdata[7:0];
      end
      if (wr_addr == byte_addr(`CSD_IDX_HOLE_TOP)) begin
        hole_top_value <= hwdata[7:0];
      end
      if (wr_addr == byte_addr(`CSD_IDX_TOP_OF_MEM)) begin
        top_of_memory <= hwdata[7:0];
      end
    end
  end

  // A read right behind a write to the same word sees the new value; a dropped
  // write to an unmapped word must not show up there either
  always_comb begin
    wr_word = 32'h0;
    unique case (wr_addr)
      byte_addr(`CSD_IDX_CONTROL):     wr_word = {24'h0, hwdata[7:0] & `CSD_CONTROL_MASK};
      byte_addr(`CSD_IDX_HOLE_BOTTOM): wr_word = {24'h0, hwdata[7:0]};
      byte_addr(`CSD_IDX_HOLE_TOP):    wr_word = {24'h0, hwdata[7:0]};
      byte_addr(`CSD_IDX_TOP_OF_MEM):  wr_word = {24'h0, hwdata[7:0]};
      default:                         wr_word = 32'h0;
    endcase
  end

  always_comb begin
    next_rdata = 32'h0;
    unique case (rd_addr)
      byte_addr(`CSD_IDX_CONTROL):     next_rdata = {24'h0, control};
      byte_addr(`CSD_IDX_HOLE_BOTTOM): next_rdata = {24'h0, hole_bottom_value};
      byte_addr(`CSD_IDX_HOLE_TOP):    next_rdata = {24'h0, hole_top_value};
      byte_addr(`CSD_IDX_TOP_OF_MEM):  next_rdata = {24'h0, top_of_memory};
      default:                         next_rdata = 32'h0;
    endcase
    if (wr_pending && wr_addr == rd_addr) begin
      next_rdata = wr_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hrdata <= 32'h0;
    end else if (access && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  csd_dir_type dir;
  logic        in_low;
  logic        in_mid;
  logic        in_bios;
  logic        in_upper;
  logic        in_hole;
  logic        hit;
  logic        next_select;

  // Only memory commands are decoded, split by direction
  always_comb begin
    dir = csd_none;
    unique case (pci_cmd)
      `CSD_CMD_MEM_RD:      dir = csd_read;
      `CSD_CMD_MEM_RD_MULT: dir = csd_read;
      `CSD_CMD_MEM_RD_LINE: dir = csd_read;
      `CSD_CMD_MEM_WR:      dir = csd_write;
      `CSD_CMD_MEM_WR_INV:  dir = csd_write;
      default: dir = csd_none;
    endcase
  end

  assign in_low  = pci_ad[31:19] == 13'h0000;
  assign in_mid  = pci_ad[31:20] == 12'h000 && pci_ad[19:17] == 3'h4;
  assign in_bios = pci_ad[31:16] == 16'h000f;

  // Top register bit 0 stands for AD21 so 00h leaves the region empty and 01h ends it at 4M-1
  assign in_upper = pci_ad[31:29] == 3'h0 && pci_ad[28:21] != 8'h00
                    && pci_ad[28:21] <= top_of_memory;

  // Software keeps the hole above 1M; no check is made here
  assign in_hole = pci_ad[31:24] == 8'h00
                   && pci_ad[23:16] >= hole_bottom_value
                   && pci_ad[23:16] <= hole_top_value;

  always_comb begin
    hit = in_low || in_upper;
    if (in_mid) begin
      hit = dir == csd_read  ? control[`CSD_BIT_MID_RD] : control[`CSD_BIT_MID_WR];
    end
    if (in_bios) begin
      hit = dir == csd_read  ? control[`CSD_BIT_BIOS_RD] : control[`CSD_BIT_BIOS_WR];
    end
  end

  assign next_select = master_en && pci_addr_phase && dir != csd_none
                       && hit && !in_hole;

  // Chip-select holds one cycle after the address phase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      main_memory_chip_select_n <= 1'b1;
    end else begin
      main_memory_chip_select_n <= !next_select;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      positive_decode_disable <= 1'b0;
    end else begin
      positive_decode_disable <= master_en;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_mem_phase;
    pci_addr_phase && dir != csd_none && !in_hole;
  endsequence

  sequence s_select_next;
    ##1 !main_memory_chip_select_n;
  endsequence

  a_cs_disabled: assert property (@(posedge clk) disable iff (!reset_n)
    !master_en |=> main_memory_chip_select_n)
    else $error("chip-select with master enable clear");

  a_low_segment: assert property (@(posedge clk) disable iff (!reset_n)
    s_mem_phase and (master_en && in_low && !in_mid) |-> s_select_next)
    else $error("low segment not selected");

  a_bios_write: assert property (@(posedge clk) disable iff (!reset_n)
    s_mem_phase and (master_en && in_bios && dir == csd_write)
    |=> main_memory_chip_select_n == !$past(control[`CSD_BIT_BIOS_WR]))
    else $error("bios write gating wrong");

  a_bios_read: assert property (@(posedge clk) disable iff (!reset_n)
    s_mem_phase and (master_en && in_bios && dir == csd_read)
    |=> main_memory_chip_select_n == !$past(control[`CSD_BIT_BIOS_RD]))
    else $error("bios read gating wrong");

  a_mid_write: assert property (@(posedge clk) disable iff (!reset_n)
    s_mem_phase and (master_en && in_mid && dir == csd_write)
    |=> main_memory_chip_select_n == !$past(control[`CSD_BIT_MID_WR]))
    else $error("mid write gating wrong");

  a_mid_read: assert property (@(posedge clk) disable iff (!reset_n)
    s_mem_phase and (master_en && in_mid && dir == csd_read)
    |=> main_memory_chip_select_n == !$past(control[`CSD_BIT_MID_RD]))
    else $error("mid read gating wrong");

  a_hole_block: assert property (@(posedge clk) disable iff (!reset_n)
    pci_addr_phase && pci_ad[31:24] == 8'h00 && pci_ad[23:16] >= hole_bottom_value
    && pci_ad[23:16] <= hole_top_value |=> main_memory_chip_select_n)
    else $error("chip-select inside hole");

  a_upper_range: assert property (@(posedge clk) disable iff (!reset_n)
    s_mem_phase and (master_en && pci_ad[31:29] == 3'h0 && pci_ad[28:21] != 8'h00
    && pci_ad[28:21] <= top_of_memory) |-> s_select_next)
    else $error("upper region not selected");

  a_above_top: assert property (@(posedge clk) disable iff (!reset_n)
    pci_addr_phase && pci_ad[31:21] > {3'h0, top_of_memory} |=> main_memory_chip_select_n)
    else $error("chip-select above top of memory");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    control[7:5] == 3'h0)
    else $error("reserved control bits set");

  a_subtractive: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 positive_decode_disable == $past(master_en))
    else $error("subtractive claim not tracking enable");

  a_reset_hole: assert property (@(posedge clk)
    !reset_n |=> hole_bottom_value == 8'h10 && hole_top_value == 8'h0f)
    else $error("hole reset values wrong");

  a_cs_reset: assert property (@(posedge clk)
    !reset_n |=> main_memory_chip_select_n)
    else $error("chip-select during reset");

  a_cs_source: assert property (@(posedge clk) disable iff (!reset_n)
    !main_memory_chip_select_n |-> $past(pci_addr_phase) && $past(master_en))
    else $error("chip-select without an enabled address phase");

  a_pdd_reset: assert property (@(posedge clk)
    !reset_n |=> !positive_decode_disable)
    else $error("subtractive claim during reset");

  // ****************************************
  // Hole and upper region checks
  // ****************************************
  // Upper region hit rebuilt from the port values, not from in_upper
  sequence s_upper_hit;
    pci_addr_phase && master_en && dir != csd_none && pci_ad[31:29] == 3'h0
    && pci_ad[28:21] != 8'h00 && pci_ad[28:21] <= top_of_memory;
  endsequence

  a_hole_disabled: assert property (@(posedge clk) disable iff (!reset_n)
    s_upper_hit and (hole_top_value < hole_bottom_value) |-> s_select_next)
    else $error("disabled hole still blocks");

  a_hole_above: assert property (@(posedge clk) disable iff (!reset_n)
    s_upper_hit and (pci_ad[31:24] != 8'h00) |-> s_select_next)
    else $error("hole applied above 16M");

  a_hole_below: assert property (@(posedge clk) disable iff (!reset_n)
    s_upper_hit and (pci_ad[31:24] == 8'h00 && pci_ad[23:16] < hole_bottom_value)
    |-> s_select_next)
    else $error("hole blocks below its bottom");

  a_hole_beyond: assert property (@(posedge clk) disable iff (!reset_n)
    s_upper_hit and (pci_ad[31:24] == 8'h00 && pci_ad[23:16] > hole_top_value)
    |-> s_select_next)
    else $error("hole blocks beyond its top block");

  // ****************************************
  // Command and segment checks
  // ****************************************
  a_idle_high: assert property (@(posedge clk) disable iff (!reset_n)
    !pci_addr_phase |=> main_memory_chip_select_n)
    else $error("chip-select outside an address phase");

  a_cmd_filter: assert property (@(posedge clk) disable iff (!reset_n)
    pci_addr_phase && !(pci_cmd inside {`CSD_CMD_MEM_RD, `CSD_CMD_MEM_WR,
    `CSD_CMD_MEM_RD_MULT, `CSD_CMD_MEM_RD_LINE, `CSD_CMD_MEM_WR_INV})
    |=> main_memory_chip_select_n)
    else $error("chip-select for a non-memory command");

  a_mid_closed: assert property (@(posedge clk) disable iff (!reset_n)
    pci_addr_phase && in_mid && !control[`CSD_BIT_MID_RD] && !control[`CSD_BIT_MID_WR]
    |=> main_memory_chip_select_n)
    else $error("closed mid segment selected");

  a_bios_closed: assert property (@(posedge clk) disable iff (!reset_n)
    pci_addr_phase && in_bios && !control[`CSD_BIT_BIOS_RD] && !control[`CSD_BIT_BIOS_WR]
    |=> main_memory_chip_select_n)
    else $error("closed bios segment selected");

  // ****************************************
  // Register bus checks
  // ****************************************
  a_control_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_pending && wr_addr == byte_addr(`CSD_IDX_CONTROL)
    |=> control == ($past(hwdata[7:0]) & `CSD_CONTROL_MASK))
    else $error("control write lost or reserved bits kept");

  a_bottom_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_pending && wr_addr == byte_addr(`CSD_IDX_HOLE_BOTTOM)
    |=> hole_bottom_value == $past(hwdata[7:0]))
    else $error("hole bottom write lost");

  a_top_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_pending && wr_addr == byte_addr(`CSD_IDX_HOLE_TOP)
    |=> hole_top_value == $past(hwdata[7:0]))
    else $error("hole top write lost");

  a_tom_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_pending && wr_addr == byte_addr(`CSD_IDX_TOP_OF_MEM)
    |=> top_of_memory == $past(hwdata[7:0]))
    else $error("top of memory write lost");

  a_read_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    access && !hwrite && rd_addr == byte_addr(`CSD_IDX_CONTROL) |=> hrdata[7:5] == 3'h0)
    else $error("reserved control bits read back set");

endmodule

// ==== tb/csd_pci_master.sv ====
// PCI bus master model presenting address phases with any bus command to the decoder
`timescale 1ns/1ns
module csd_pci_master (
  input  wire logic        clk,            // PCI clock
  output logic             pci_addr_phase, // Address phase strobe
  output logic [31:0]      pci_ad,         // Address lines
  output logic [3:0]       pci_cmd         // Bus command
);
  initial begin
    pci_addr_phase = 1'b0;
    pci_ad         = 32'h0;
    pci_cmd        = 4'h0;
  end
  // One address phase; afterwards the lines show the inverse so stale values never decode
  task automatic issue(input logic [31:0] a, input logic [3:0] c);
    @(posedge clk);
    pci_addr_phase <= 1'b1;
    pci_ad         <= a;
    pci_cmd        <= c;
    @(posedge clk);
    pci_addr_phase <= 1'b0;
    pci_ad         <= ~a;
    pci_cmd        <= ~c;
  endtask
endmodule

// ==== tb/pci_memory_chip_select_decoder_tb_top.sv ====
// Self-checking bench for the chip-select decoder
`timescale 1ns/1ns
`include "csd_defines.svh"
module pci_memory_chip_select_decoder_tb_top;
  import csd_pkg::*;
  logic        clk, reset_n, hsel, hwrite, hreadyout, hresp, cs_n, pdd, exp_n;
  logic [31:0] haddr, hwdata, hrdata, rd, pci_ad;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        pci_addr_phase;
  logic [3:0]  pci_cmd;
  int          n_fail, cmp_count, cycles;
  // ****************************************
  // Stimulus tables: {control, hole bottom, hole top, top of memory}
  // ****************************************
  logic [31:0] cfg [7] = '{32'h0020_1fff, 32'h1020_1f00, 32'h1120_1f01, 32'h1220_1f01,
                           32'h1420_21ff, 32'h1830_2fff, 32'hff10_10ff};
  logic [31:0] adr [19] = '{32'h0, 32'h7ffff, 32'h80000, 32'h9ffff, 32'ha0000, 32'heffff,
                            32'hf0000, 32'hfffff, 32'h100000, 32'h10ffff, 32'h110000,
                            32'h1fffff, 32'h200000, 32'h21ffff, 32'h220000, 32'h3fffff,
                            32'h1fffffff, 32'h20000000, 32'h01200000};
  logic [3:0]  cmds [7] = '{4'h6, 4'h7, 4'hc, 4'he, 4'hf, 4'h2, 4'h3};
  logic [7:0]  rstv [4] = '{`CSD_RST_CONTROL, `CSD_RST_HOLE_BOTTOM, `CSD_RST_HOLE_TOP,
                            `CSD_RST_TOP_OF_MEM};
  csd_decoder i_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pci_addr_phase(pci_addr_phase),
    .pci_ad(pci_ad), .pci_cmd(pci_cmd), .main_memory_chip_select_n(cs_n),
    .positive_decode_disable(pdd));
  csd_pci_master i_pci (.clk(clk), .pci_addr_phase(pci_addr_phase), .pci_ad(pci_ad),
    .pci_cmd(pci_cmd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard: the whole run needs a few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  // Single AHB-Lite transfer, waiting on hready in both phases
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask
  function automatic logic [31:0] raddr(input int i);
    return {22'h0, `CSD_IDX_CONTROL + 8'(i), 2'b00};
  endfunction
  // Expected chip-select level, active low
  function automatic logic exp_cs(input logic [31:0] k, input logic [31:0] a,
                                  input logic [3:0] c);
    logic rdc, wrc, hit, hole, mid, bios;
    rdc  = (c == 4'h6) || (c == 4'hc) || (c == 4'he);
    wrc  = (c == 4'h7) || (c == 4'hf);
    mid  = (rdc && k[24]) || (wrc && k[25]);
    bios = (rdc && k[26]) || (wrc && k[27]);
    hit  = (a < 32'h80000) ||
           (a >= 32'h80000 && a <= 32'h9ffff && mid) ||
           (a >= 32'hf0000 && a <= 32'hfffff && bios) ||
           (a[31:29] == 3'h0 && a[28:21] >= 8'h01
            && a[28:21] <= k[7:0]);
    hole = (a[31:24] == 8'h0) && (a[23:16] >= k[23:16])
           && (a[23:16] <= k[15:8]);
    return !(k[28] && (rdc || wrc) && hit && !hole);
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 check("chip_select_n after reset", {31'h0, cs_n}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, raddr(i), 32'h0, rd);
      check("reset value", rd, {24'h0, rstv[i]});
    end
    bus(1'b1, 32'h200, 32'hff, rd);
    bus(1'b0, 32'h200, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    for (int k = 0; k < 7; k++) begin
      for (int i = 0; i < 4; i++) begin
        bus(1'b1, raddr(i), {24'h0, cfg[k][31-8*i -: 8]}, rd);
      end
      for (int i = 0; i < 4; i++) begin
        bus(1'b0, raddr(i), 32'h0, rd);
        check("register readback", rd,
              {24'h0, cfg[k][31-8*i -: 8] & (i == 0 ? 8'h1f : 8'hff)});
      end
      check("positive_decode_disable", {31'h0, pdd}, {31'h0, cfg[k][28]});
      foreach (adr[a]) begin
        foreach (cmds[c]) begin
          exp_n = exp_cs(cfg[k], adr[a], cmds[c]);
          i_pci.issue(adr[a], cmds[c]);
          #1 check("chip_select_n", {31'h0, cs_n}, {31'h0, exp_n});
        end
      end
    end
    // Mid-run reset must restore every register, whatever was written before
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 check("chip_select_n after reset", {31'h0, cs_n}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, raddr(i), 32'h0, rd);
      check("reset value", rd, {24'h0, rstv[i]});
    end
    check("positive_decode_disable", {31'h0, pdd}, 32'h0);
    give_verdict();
  end
endmodule
